// ### shared/cfg_boot_cfg.svh
// constants for the configuration boot and soft error controller
`ifndef CFG_BOOT_CFG_SVH
`define CFG_BOOT_CFG_SVH
// --------------------------------------------------------------
// clock figures
// --------------------------------------------------------------
`define REF_CLK_KHZ 200000
`define MCLK_INIT_KHZ 3100
`define MCLK_DEFAULT_KHZ 2500
`define OSC_NOMINAL_KHZ 130000
// --------------------------------------------------------------
// stream words and fields
// --------------------------------------------------------------
`define W_SYNC 32'hBDB3_0000
`define W_CLKSEL 32'hC10C_0000
`define W_VERSION 32'hAE50_0000
`define W_END 32'hE0D0_0000
`define OP_MASK 32'hFFFF_0000
`define CLKSEL_DIV_LSB 0
`define CLKSEL_DIV_W 8
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'h04C1_1DB7
`define ZERO8 8'h00
`endif

// ### shared/cfg_boot_pkg.sv
// types shared by the configuration boot controller
`default_nettype none
package cfg_boot_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD, ST_CHECK, ST_FALLBACK, ST_USER
    } boot_state_t;
    typedef enum logic [1:0] {
        SCAN_OFF, SCAN_RUN, SCAN_HIT
    } scan_state_t;
endpackage
`default_nettype wire

// ### core/crc32_step.sv
// one word step of the stream integrity crc
`timescale 1ns/1ps
`default_nettype none
`include "cfg_boot_cfg.svh"
module crc32_step (
    input wire logic [31:0] crc_in, // running remainder
    input wire logic [31:0] data_in, // incoming word
    output logic [31:0] crc_out // updated remainder
);
    // bitwise loop over the word, msb first
    always_comb
    begin
        logic [31:0] c;
        c = crc_in;
        for (int i = 31; i >= 0; i--)
        begin
            if (c[31] ^ data_in[i])
                c = {c[30:0], 1'b0} ^ `CRC_POLY;
            else
                c = {c[30:0], 1'b0};
        end
        crc_out = c;
    end
endmodule
`default_nettype wire

// ### core/config_boot_and_soft_error_ctrl.sv
// configuration loader: master clock, stream crc, dual boot, io hold, soft error scan
// Notes on behaviour
// - master clock starts at initial frequency
// - switch to selected rate after clock word
// - no selection in stream gives default rate
// - oscillator and master clock run continuously
// - oscillator selectable as user clock source
// - crc computed over received configuration stream
// - background scan while user logic runs
// - upset in user mode raises error output
// - hold io pins during field update
// - bad new image reloads golden and retries
// - reboot or fallback by trigger, no power cycle
`timescale 1ns/1ps
`default_nettype none
`include "cfg_boot_cfg.svh"
module config_boot_and_soft_error_ctrl
    import cfg_boot_pkg::*;
#(
    parameter int SCAN_WORDS = 64, // configuration memory words scanned per pass
    parameter logic [31:0] GOLDEN_BASE = 32'h0000_0000, // golden image location
    parameter logic [31:0] UPDATE_BASE = 32'h0010_0000, // new image location
    parameter logic [15:0] EXPECT_VER = 16'h0001 // accepted version number
) (
    input wire logic ref_clk, // 200 MHz system clock
    input wire logic resetn, // async reset, low active
    input wire logic reboot_req, // pulse: triggered reconfiguration
    input wire logic boot_new_image, // level: try update image on reboot
    input wire logic io_hold_during_update, // level: freeze pins on reconfig
    input wire logic [31:0] cfg_data, // stream word from storage
    input wire logic cfg_valid, // stream word strobe
    output logic [31:0] image_addr, // storage start address being loaded
    output logic image_fetch, // level: reading an image
    input wire logic soft_error_scan_en, // level: enable background scan
    input wire logic [31:0] mem_word, // configuration memory word at scan index
    input wire logic [31:0] mem_ref, // stored reference for that word
    output logic [$clog2(SCAN_WORDS)-1:0] scan_idx, // word being scanned
    input wire logic user_clk_sel_osc, // level: pick oscillator for user tree
    input wire logic user_clk_alt, // alternate user clock source
    input wire logic osc_clk, // internal oscillator
    output logic user_clk_src, // user clock tree source
    output logic config_master_clock, // master configuration clock
    output logic config_done, // level: user mode
    output logic io_freeze, // level: output pins held
    output logic crc_error, // level: last load failed crc
    output logic soft_error // level: upset seen in user mode
);
    localparam logic [31:0] INIT_DIV = 32'(`REF_CLK_KHZ / (2 * `MCLK_INIT_KHZ));
    localparam logic [31:0] DEF_DIV = 32'(`REF_CLK_KHZ / (2 * `MCLK_DEFAULT_KHZ));
    localparam int IW = $clog2(SCAN_WORDS);

    boot_state_t state_r;
    scan_state_t scan_r;
    logic [31:0] crc_r, crc_nxt, div_r, div_cnt_r;
    logic clk_sel_seen_r, tried_golden_r, ver_ok_r, crc_chk_r;
    logic word_sync, word_clk, word_ver, word_end;

    crc32_step u_crc (
        .crc_in(crc_r),
        .data_in(cfg_data),
        .crc_out(crc_nxt)
    );

    // --------------------------------------------------------------
    // stream decode
    // --------------------------------------------------------------
    assign word_sync = cfg_valid && ((cfg_data & `OP_MASK) == `W_SYNC);
    assign word_clk = cfg_valid && ((cfg_data & `OP_MASK) == `W_CLKSEL);
    assign word_ver = cfg_valid && ((cfg_data & `OP_MASK) == `W_VERSION);
    assign word_end = cfg_valid && ((cfg_data & `OP_MASK) == `W_END);

    // boot sequencer; a failed update image drops back to golden once
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= ST_LOAD;
            tried_golden_r <= 1'b1;
        end
        else
        begin
            case (state_r)
                ST_IDLE: state_r <= ST_LOAD;
                ST_LOAD: if (word_end) state_r <= ST_CHECK;
                ST_CHECK:
                    if (crc_chk_r && ver_ok_r)
                        state_r <= ST_USER;
                    else if (!tried_golden_r)
                        state_r <= ST_FALLBACK;
                    else
                        state_r <= ST_IDLE; // golden bad too: retry golden
                ST_FALLBACK:
                begin
                    tried_golden_r <= 1'b1;
                    state_r <= ST_LOAD;
                end
                ST_USER:
                    if (reboot_req)
                    begin
                        tried_golden_r <= !boot_new_image;
                        state_r <= ST_LOAD;
                    end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // image address follows which copy is being tried; images kept apart
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            image_addr <= GOLDEN_BASE;
        else if (state_r == ST_USER && reboot_req)
            image_addr <= boot_new_image ? UPDATE_BASE : GOLDEN_BASE;
        else if (state_r == ST_FALLBACK)
            image_addr <= GOLDEN_BASE;
    end

    // crc over every stream word before the end word; the end word carries the low 16 bits of the expected remainder
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            crc_r <= `CRC_INIT;
            crc_chk_r <= 1'b0;
            ver_ok_r <= 1'b0;
        end
        else if (state_r != ST_LOAD)
            crc_r <= `CRC_INIT;
        else if (word_end)
            crc_chk_r <= (crc_r[15:0] == cfg_data[15:0]);
        else if (cfg_valid)
        begin
            crc_r <= crc_nxt;
            if (word_ver)
                ver_ok_r <= (cfg_data[15:0] == EXPECT_VER);
        end
    end

    // --------------------------------------------------------------
    // master clock divider
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_r <= INIT_DIV;
            clk_sel_seen_r <= 1'b0;
        end
        else if (state_r == ST_LOAD && word_sync)
            clk_sel_seen_r <= 1'b0;
        else if (state_r == ST_LOAD && word_clk
                 && cfg_data[`CLKSEL_DIV_LSB +: `CLKSEL_DIV_W] != `ZERO8)
        begin
            div_r <= {24'h00_0000, cfg_data[`CLKSEL_DIV_LSB +: `CLKSEL_DIV_W]};
            clk_sel_seen_r <= 1'b1;
        end
        else if (state_r == ST_LOAD && word_end && !clk_sel_seen_r)
            div_r <= DEF_DIV;
    end

    // free-running toggle; never gated by state
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_cnt_r <= 32'h0000_0000;
            config_master_clock <= 1'b0;
        end
        else if (div_cnt_r + 32'h0000_0001 >= div_r)
        begin
            div_cnt_r <= 32'h0000_0000;
            config_master_clock <= !config_master_clock;
        end
        else
            div_cnt_r <= div_cnt_r + 32'h0000_0001;
    end

    // oscillator offered to the user tree once configured; a clock mux, kept glue-free
    assign user_clk_src = (config_done && user_clk_sel_osc) ? osc_clk : user_clk_alt;

    // --------------------------------------------------------------
    // status and io freeze
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            config_done <= 1'b0;
            io_freeze <= 1'b0;
            crc_error <= 1'b0;
            image_fetch <= 1'b1;
        end
        else
        begin
            config_done <= (state_r == ST_CHECK && crc_chk_r && ver_ok_r)
                        || (state_r == ST_USER && !reboot_req);
            image_fetch <= (state_r != ST_USER) || reboot_req;
            if (state_r == ST_USER && reboot_req)
                io_freeze <= io_hold_during_update;
            else if (state_r == ST_CHECK && crc_chk_r && ver_ok_r)
                io_freeze <= 1'b0;
            if (state_r == ST_CHECK)
                crc_error <= !crc_chk_r;
        end
    end

    // --------------------------------------------------------------
    // background soft error scan
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scan_r <= SCAN_OFF;
            scan_idx <= '0;
        end
        else
        begin
            case (scan_r)
                SCAN_OFF:
                begin
                    scan_idx <= '0;
                    if (soft_error_scan_en && state_r == ST_USER)
                        scan_r <= SCAN_RUN;
                end
                SCAN_RUN:
                    if (!soft_error_scan_en || state_r != ST_USER)
                        scan_r <= SCAN_OFF;
                    else if (mem_word != mem_ref)
                        scan_r <= SCAN_HIT;
                    else if (scan_idx == IW'(SCAN_WORDS - 1))
                        scan_idx <= '0;
                    else
                        scan_idx <= scan_idx + IW'(1);
                SCAN_HIT: scan_r <= SCAN_RUN; // keep scanning after a hit
                default: scan_r <= SCAN_OFF;
            endcase
        end
    end

    // sticky error, cleared only by a new load
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            soft_error <= 1'b0;
        else if (scan_r == SCAN_HIT && state_r == ST_USER)
            soft_error <= 1'b1;
        else if (state_r == ST_LOAD)
            soft_error <= 1'b0;
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    chk_init_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(resetn) |-> div_r == INIT_DIV)
        else $error("master clock not at initial rate");
    chk_clk_select: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_LOAD && word_clk
         && cfg_data[`CLKSEL_DIV_LSB +: `CLKSEL_DIV_W] != `ZERO8)
        |=> div_r[`CLKSEL_DIV_LSB +: `CLKSEL_DIV_W]
            == $past(cfg_data[`CLKSEL_DIV_LSB +: `CLKSEL_DIV_W]))
        else $error("selected rate not applied");
    chk_default_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_LOAD && word_end && !clk_sel_seen_r) |=> div_r == DEF_DIV)
        else $error("default rate not applied");
    chk_clk_runs: assert property (@(posedge ref_clk) disable iff (!resetn)
        (div_cnt_r + 32'h0000_0001 >= div_r) |=> config_master_clock != $past(config_master_clock))
        else $error("master clock stalled");
    chk_fallback_golden: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_r == ST_FALLBACK |=> image_addr == GOLDEN_BASE && state_r == ST_LOAD)
        else $error("fallback did not reload golden");
    // reload begins, and config_done is still low one cycle later
    sequence reload_starts;
        state_r == ST_LOAD ##1 !config_done;
    endsequence
    chk_reboot_trigger: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_USER && reboot_req) |=> reload_starts)
        else $error("reboot trigger ignored");
    chk_io_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_USER && reboot_req && io_hold_during_update)
        |=> io_freeze throughout (state_r != ST_USER)[*2])
        else $error("io not held during update");
    chk_soft_err: assert property (@(posedge ref_clk) disable iff (!resetn)
        (scan_r == SCAN_HIT && state_r == ST_USER) |=> soft_error)
        else $error("upset not reported");
    chk_scan_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
        (scan_r == SCAN_RUN && soft_error_scan_en && state_r == ST_USER
         && mem_word == mem_ref && scan_idx == IW'(SCAN_WORDS - 1)) |=> scan_idx == '0)
        else $error("scan did not restart");
endmodule
`default_nettype wire

// ### testbench/cfg_store_model.sv
// configuration storage model serving boot images
`timescale 1ns/1ps
`default_nettype none
`include "cfg_boot_cfg.svh"
module cfg_store_model #(
    parameter logic [31:0] UPDATE_BASE = 32'h0010_0000, // new image place
    parameter logic [15:0] EXPECT_VER = 16'h0001 // good version
) (
    input wire logic clk, // system clock
    input wire logic go, // start serving
    input wire logic [31:0] image_addr, // image asked for
    input wire logic config_done, // user mode
    input wire logic crc_error, // load failed
    input wire logic [7:0] div, // clock select, 0 leaves it out
    input wire logic [1:0] fault, // update: 1 bad version, 2 bad crc
    output logic [31:0] cfg_data, // stream word
    output logic cfg_valid // word strobe
);
    logic [31:0] crc;
    logic [31:0] img[$];
    logic upd;
    // ----------------------------------------
    // stream source
    // ----------------------------------------
    // one word into the running crc, msb first
    function automatic logic [31:0] step(input logic [31:0] c, input logic [31:0] d);
        for (int i = 31; i >= 0; i--)
        begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `CRC_POLY : 32'h0000_0000);
        end
        return c;
    endfunction
    // serve the image at image_addr each time a load starts
    initial
    begin
        cfg_valid = 1'b0;
        cfg_data = 32'h0000_0000;
        wait (go);
        forever
        begin
            upd = (image_addr === UPDATE_BASE);
            img = {`W_SYNC};
            if (div != 8'h00)
                img.push_back(`W_CLKSEL | div);
            img.push_back(`W_VERSION | (upd && fault == 2'd1 ? EXPECT_VER + 16'd1 : EXPECT_VER));
            crc = `CRC_INIT;
            foreach (img[i])
                crc = step(crc, img[i]);
            img.push_back(`W_END | (crc[15:0] ^ {15'h0000, upd && fault == 2'd2}));
            foreach (img[i])
            begin
                @(negedge clk);
                cfg_data = img[i];
                cfg_valid = 1'b1;
            end
            @(negedge clk);
            cfg_valid = 1'b0;
            cfg_data = ~cfg_data; // a released bus never keeps the last word
            repeat (2) @(negedge clk);
            // a failed load falls back one cycle later, else wait for a reboot
            if (crc_error)
                @(negedge clk);
            else
                @(negedge clk iff !config_done);
        end
    end
endmodule
`default_nettype wire

// ### testbench/config_boot_and_soft_error_ctrl_test.sv
// self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "cfg_boot_cfg.svh"
module config_boot_and_soft_error_ctrl_test;
    localparam logic [31:0] UPD = 32'h0010_0000;
    localparam int SW = 8;
    logic ref_clk, resetn, reboot_req, boot_new_image, io_hold_during_update;
    logic [31:0] cfg_data, image_addr, mem_word, mem_ref;
    logic cfg_valid, image_fetch, soft_error_scan_en, user_clk_sel_osc, user_clk_alt;
    logic osc_clk, user_clk_src, config_master_clock, config_done, io_freeze;
    logic crc_error, soft_error, go, flip;
    logic [2:0] scan_idx;
    logic [7:0] div;
    logic [1:0] fault;
    int n_mismatch = 0;
    int compares = 0;
    config_boot_and_soft_error_ctrl #(.SCAN_WORDS(SW)) u_config_boot_and_soft_error_ctrl (
        .ref_clk(ref_clk), .resetn(resetn), .reboot_req(reboot_req),
        .boot_new_image(boot_new_image), .io_hold_during_update(io_hold_during_update),
        .cfg_data(cfg_data), .cfg_valid(cfg_valid), .image_addr(image_addr),
        .image_fetch(image_fetch), .soft_error_scan_en(soft_error_scan_en),
        .mem_word(mem_word), .mem_ref(mem_ref), .scan_idx(scan_idx),
        .user_clk_sel_osc(user_clk_sel_osc), .user_clk_alt(user_clk_alt),
        .osc_clk(osc_clk), .user_clk_src(user_clk_src),
        .config_master_clock(config_master_clock), .config_done(config_done),
        .io_freeze(io_freeze), .crc_error(crc_error), .soft_error(soft_error));
    cfg_store_model #(.UPDATE_BASE(UPD)) u_cfg_store_model (
        .clk(ref_clk), .go(go), .image_addr(image_addr), .config_done(config_done),
        .crc_error(crc_error), .div(div), .fault(fault), .cfg_data(cfg_data),
        .cfg_valid(cfg_valid));
    // ----------------------------------------
    // clock, random inputs and helpers
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // memory words match their reference unless flip injects an upset
    assign mem_word = mem_ref ^ {31'h0000_0000, flip};
    always @(negedge ref_clk)
    begin
        mem_ref <= $urandom;
        {osc_clk, user_clk_alt} <= 2'($urandom);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // wait for user mode under a bound, noting any crc failure on the way
    task automatic wait_load(output logic err);
        int n;
        err = 1'b0;
        n = 0;
        while (config_done !== 1'b1)
        begin
            @(negedge ref_clk);
            err = err | crc_error;
            n++;
            if (n > 400)
            begin
                n_mismatch++;
                end_sim();
            end
        end
    endtask
    // half period of the master clock in reference cycles, 600 if stuck
    task automatic half(output int hp);
        logic v;
        hp = 0;
        @(negedge ref_clk);
        v = config_master_clock;
        for (int i = 0; i < 600 && config_master_clock === v; i++)
            @(negedge ref_clk);
        v = config_master_clock;
        while (config_master_clock === v && hp < 600)
        begin
            @(negedge ref_clk);
            hp++;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic err;
        int hp;
        logic [7:0] d;
        logic [2:0] i0;
        {resetn, reboot_req, boot_new_image, io_hold_during_update, go, flip} = 6'h00;
        {soft_error_scan_en, user_clk_sel_osc} = 2'h0;
        {div, fault} = 10'h000;
        void'($urandom(32'he9cfe8fa));
        cyc(10);
        resetn = 1'b1;
        check({image_fetch, config_done, io_freeze, crc_error, soft_error}, 5'b10000);
        half(hp);
        check(hp, `REF_CLK_KHZ / (2 * `MCLK_INIT_KHZ));
        d = 8'(2 + $urandom % 30);
        div = d;
        go = 1'b1;
        wait_load(err);
        check(err, 1'b0);
        half(hp);
        check(hp, d);
        // user tree source follows the select once configured
        for (int i = 0; i < 4; i++)
        begin
            user_clk_sel_osc = i[0];
            cyc(1);
            #1;
            check(user_clk_src, i[0] ? osc_clk : user_clk_alt);
        end
        soft_error_scan_en = 1'b1;
        cyc(2);
        i0 = scan_idx;
        cyc(1);
        check(scan_idx, 3'(i0 + 3'd1));
        cyc(SW - 1);
        check(scan_idx, i0);
        check(soft_error, 1'b0);
        flip = 1'b1;
        cyc(1);
        flip = 1'b0;
        cyc(2);
        check(soft_error, 1'b1);
        // bad version, bad crc, then a good update without clock select
        for (int f = 1; f < 4; f++)
        begin
            fault = 2'(f % 3);
            div = (f == 3) ? 8'h00 : d;
            boot_new_image = 1'b1;
            io_hold_during_update = f[0];
            reboot_req = 1'b1;
            cyc(1);
            reboot_req = 1'b0;
            cyc(1);
            #1;
            check(image_addr, UPD);
            check(io_freeze, f[0]);
            check(image_fetch, 1'b1);
            check(user_clk_src, user_clk_alt);
            wait_load(err);
            check(err, f == 2);
            check(image_addr, (f == 3) ? UPD : 32'h0000_0000);
            check({soft_error, io_freeze}, 2'b00);
            half(hp);
            check(hp, (f == 3) ? `REF_CLK_KHZ / (2 * `MCLK_DEFAULT_KHZ) : d);
            check(image_fetch, 1'b0);
        end
        end_sim();
    end
endmodule
`default_nettype wire
